// ==== rtl/sls_pkg.sv ====
// shared constants, carriers and helpers of the serdes link lock block
package sls_pkg;

  localparam int               WORD_W           = 10;
  localparam int               FRAME_W          = 12;
  localparam int               FIFO_DEPTH       = 8;
  localparam logic [3:0]       FRAME_LAST       = 4'hb;
  localparam logic [1:0]       LOSS_BAD_LAST    = 2'h3;
  localparam logic [3:0]       RANDOM_GOOD_LAST = 4'h7;
  localparam logic [10:0]      TRAIN_SYMBOLS    = 11'h400;
  localparam logic [WORD_W-1:0] TRAIN_PATTERN   = 10'h01f;
  localparam logic             LEAD_BIT         = 1'b1;
  localparam logic             TAIL_BIT         = 1'b0;

  typedef struct packed {
    logic              tail;
    logic [WORD_W-1:0] data;
    logic              lead;
  } sls_frame_s;

  typedef enum logic [0:0] {
    SLS_HUNT   = 1'b0,
    SLS_LOCKED = 1'b1
  } sls_rx_state_e;

  function automatic logic sls_frame_ok(input sls_frame_s f);
    return (f.lead == LEAD_BIT) && (f.tail == TAIL_BIT);
  endfunction

  function automatic sls_frame_s sls_make_frame(input logic [WORD_W-1:0] d);
    sls_frame_s f;
    f.lead = LEAD_BIT;
    f.data = d;
    f.tail = TAIL_BIT;
    return f;
  endfunction

endpackage

// ==== rtl/sls_sync.sv ====
// two flip-flop level synchroniser, any width
`timescale 1ns/1ps
module sls_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sls_sync_s;

  sls_sync_s st_q;
  sls_sync_s st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule

// ==== rtl/sls_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module sls_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 wptr;
    logic [PW:0]                 rptr;
    logic                        ready;
  } sls_fifo_s;

  sls_fifo_s st_q;
  sls_fifo_s st_d;
  logic      push;
  logic      pop;
  logic [PW:0] used;

  assign out_valid = (st_q.wptr != st_q.rptr);
  assign out_data  = st_q.mem[st_q.rptr[PW-1:0]];
  assign in_ready  = st_q.ready;
  assign push      = in_valid && st_q.ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    used = '0;
    if (push) begin
      st_d.mem[st_q.wptr[PW-1:0]] = in_data;
      st_d.wptr = st_q.wptr + 1'b1;
    end
    if (pop) begin
      st_d.rptr = st_q.rptr + 1'b1;
    end
    used = st_d.wptr - st_d.rptr;
    // registered ready keeps the port glitch free
    st_d.ready = (used != (PW+1)'(DEPTH));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= '0;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ==== rtl/sls_top.sv ====
// serdes pair: framing, training, lock supervision and crossings
// What this block does
// - each 10-bit word goes out serially with two clock bits added.
// - lock indicator high when lock lost, low while locked.
// - parallel_word_oe stays low until first lock after reset; parallel_word_out is always driven.
// - training patterns sent while either training request is high.
// - lock is also acquired on random data, more slowly.
// - words presented only while locked.
// - lock lost only after four consecutive bad frames; good one restarts.
// - a training request yields at least 1024 training frames.
`timescale 1ns/1ps
module sls_top
  import sls_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              local_reference_clock,
  input  wire logic [WORD_W-1:0] tx_word,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic              training_request_a,
  input  wire logic              training_request_b,
  output logic                   serial_out,
  input  wire logic              serial_in,
  output logic      [WORD_W-1:0] parallel_word_out,
  output logic                   parallel_word_oe,
  output logic                   rx_word_strobe,
  output logic                   lock_indicator
);

  // link side state, clocked by the local reference clock
  typedef struct packed {
    logic [FRAME_W-1:0] rx_sh;
    logic [3:0]         rx_cnt;
    sls_rx_state_e      rx_state;
    logic [3:0]         good_cnt;
    logic [1:0]         bad_cnt;
    logic [WORD_W-1:0]  rx_word;
    logic               rx_tgl;
    logic [3:0]         tx_cnt;
    sls_frame_s         tx_frame;
    logic               sout;
    logic [10:0]        train_cnt;
    logic               ack_tgl;
  } sls_link_s;

  // system side state
  typedef struct packed {
    logic              req_tgl;
    logic [WORD_W-1:0] hold;
    logic              rx_seen;
    logic [WORD_W-1:0] out_word;
    logic              oe;
    logic              ever_locked;
    logic              strobe;
    logic              lock_ind;
  } sls_sys_s;

  sls_link_s         ln_q;
  sls_link_s         ln_d;
  sls_sys_s          sy_q;
  sls_sys_s          sy_d;
  logic              sys_rst_n;
  logic              link_rst_n;
  logic [3:0]        link_in;
  logic [2:0]        sys_in;
  logic              req_l;
  logic              ser_in_l;
  logic              req_tgl_l;
  logic              ack_s;
  logic              rx_tgl_s;
  logic              locked_s;
  logic [WORD_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              fifo_ready;
  logic              rx_chk;
  logic              rx_ok;
  sls_frame_s        rx_win;

  sls_sync #(.WIDTH(1)) u_sys_rst (
    .clock (clock),
    .rst_n (resetn),
    .d     (1'b1),
    .q     (sys_rst_n)
  );

  sls_sync #(.WIDTH(1)) u_link_rst (
    .clock (local_reference_clock),
    .rst_n (resetn),
    .d     (1'b1),
    .q     (link_rst_n)
  );

  sls_sync #(.WIDTH(4)) u_link_sync (
    .clock (local_reference_clock),
    .rst_n (link_rst_n),
    .d     ({training_request_a, training_request_b, serial_in,
             sy_q.req_tgl}),
    .q     (link_in)
  );

  sls_sync #(.WIDTH(3)) u_sys_sync (
    .clock (clock),
    .rst_n (sys_rst_n),
    .d     ({ln_q.ack_tgl, ln_q.rx_tgl, (ln_q.rx_state == SLS_LOCKED)}),
    .q     (sys_in)
  );

  assign req_l     = link_in[3] | link_in[2];
  assign ser_in_l  = link_in[1];
  assign req_tgl_l = link_in[0];
  assign ack_s     = sys_in[2];
  assign rx_tgl_s  = sys_in[1];
  assign locked_s  = sys_in[0];

  // outgoing words wait here; back-pressure reaches tx_ready
  sls_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_n     (sys_rst_n),
    .in_data   (tx_word),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  // one word in flight to the link; hold stays put until acked
  assign fifo_ready = (sy_q.req_tgl == ack_s);

  always_comb begin
    sy_d        = sy_q;
    sy_d.strobe = 1'b0;
    if (fifo_valid && fifo_ready) begin
      sy_d.hold    = fifo_data;
      sy_d.req_tgl = ~sy_q.req_tgl;
    end
    // rx_word is stable for a whole frame once its toggle arrives
    if (rx_tgl_s != sy_q.rx_seen) begin
      sy_d.rx_seen  = rx_tgl_s;
      sy_d.out_word = ln_q.rx_word;
      sy_d.strobe   = 1'b1;
    end
    sy_d.lock_ind = ~locked_s;
    if (locked_s) begin
      sy_d.ever_locked = 1'b1;
    end
    sy_d.oe = sy_q.ever_locked | locked_s;
  end

  always_ff @(posedge clock or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sy_q          <= '0;
      sy_q.lock_ind <= 1'b1;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign parallel_word_out = sy_q.out_word;
  assign parallel_word_oe  = sy_q.oe;
  assign rx_word_strobe    = sy_q.strobe;
  assign lock_indicator    = sy_q.lock_ind;

  // receive window: oldest bit sits in bit 0
  assign rx_win = sls_frame_s'({ser_in_l, ln_q.rx_sh[FRAME_W-1:1]});
  assign rx_chk = (ln_q.rx_cnt == FRAME_LAST);
  assign rx_ok  = sls_frame_ok(rx_win);

  always_comb begin
    ln_d       = ln_q;
    ln_d.rx_sh = rx_win;
    case (ln_q.rx_state)
      SLS_HUNT: begin
        if (rx_chk && rx_ok) begin
          ln_d.rx_cnt   = 4'h0;
          ln_d.good_cnt = ln_q.good_cnt + 1'b1;
          // training frames lock at once, random data needs a run
          if (rx_win.data == TRAIN_PATTERN ||
              ln_q.good_cnt == RANDOM_GOOD_LAST) begin
            ln_d.rx_state = SLS_LOCKED;
            ln_d.good_cnt = 4'h0;
            ln_d.bad_cnt  = 2'h0;
          end
        end else if (rx_chk) begin
          // slip one bit and look again next cycle
          ln_d.good_cnt = 4'h0;
        end else begin
          ln_d.rx_cnt = ln_q.rx_cnt + 1'b1;
        end
      end
      SLS_LOCKED: begin
        ln_d.rx_cnt = rx_chk ? 4'h0 : ln_q.rx_cnt + 1'b1;
        if (rx_chk && rx_ok) begin
          ln_d.bad_cnt = 2'h0;
          ln_d.rx_word = rx_win.data;
          ln_d.rx_tgl  = ~ln_q.rx_tgl;
        end else if (rx_chk) begin
          if (ln_q.bad_cnt == LOSS_BAD_LAST) begin
            ln_d.rx_state = SLS_HUNT;
            ln_d.bad_cnt  = 2'h0;
            ln_d.good_cnt = 4'h0;
          end else begin
            ln_d.bad_cnt = ln_q.bad_cnt + 1'b1;
          end
        end
      end
      default: begin
        ln_d.rx_state = SLS_HUNT;
      end
    endcase

    // transmit side
    ln_d.tx_cnt = (ln_q.tx_cnt == FRAME_LAST) ? 4'h0 : ln_q.tx_cnt + 1'b1;
    ln_d.sout   = ln_q.tx_frame[ln_q.tx_cnt];
    if (req_l) begin
      ln_d.train_cnt = TRAIN_SYMBOLS;
    end else if (ln_q.tx_cnt == FRAME_LAST && ln_q.train_cnt != 11'h000) begin
      ln_d.train_cnt = ln_q.train_cnt - 1'b1;
    end
    if (ln_q.tx_cnt == FRAME_LAST) begin
      if (req_l || ln_q.train_cnt != 11'h000) begin
        ln_d.tx_frame = sls_make_frame(TRAIN_PATTERN);
      end else if (req_tgl_l != ln_q.ack_tgl) begin
        ln_d.tx_frame = sls_make_frame(sy_q.hold);
        ln_d.ack_tgl  = ~ln_q.ack_tgl;
      end else begin
        // idle frames also carry the training pattern
        ln_d.tx_frame = sls_make_frame(TRAIN_PATTERN);
      end
    end
  end

  always_ff @(posedge local_reference_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ln_q        <= '0;
      // start on a frame boundary so no unframed bits go out after reset
      ln_q.tx_cnt <= FRAME_LAST;
    end else begin
      ln_q <= ln_d;
    end
  end

  assign serial_out = ln_q.sout;

  AST_LOSS_AFTER_FOUR: assert property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    ln_q.rx_state == SLS_LOCKED && rx_chk && !rx_ok &&
    ln_q.bad_cnt == LOSS_BAD_LAST |=> ln_q.rx_state == SLS_HUNT)
    else $error("lock not dropped after four bad frames");

  AST_HOLD_BEFORE_FOUR: assert property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    ln_q.rx_state == SLS_LOCKED && rx_chk && !rx_ok &&
    ln_q.bad_cnt != LOSS_BAD_LAST
    |=> ln_q.rx_state == SLS_LOCKED &&
        ln_q.bad_cnt == $past(ln_q.bad_cnt) + 2'h1)
    else $error("lock dropped or count wrong before four bad frames");

  AST_GOOD_RESTARTS: assert property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    ln_q.rx_state == SLS_LOCKED && rx_chk && rx_ok
    |=> ln_q.bad_cnt == 2'h0 && ln_q.rx_tgl != $past(ln_q.rx_tgl))
    else $error("good frame did not restart bad count");

  AST_FRAME_LEAD: assert property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    ln_q.tx_cnt == 4'h0 ##1 ln_q.tx_cnt == 4'h1 |-> serial_out == LEAD_BIT)
    else $error("frame lead bit is not one");

  AST_FRAME_TAIL: assert property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    ln_q.tx_cnt == FRAME_LAST && $past(ln_q.tx_cnt) == 4'ha
    |=> serial_out == TAIL_BIT)
    else $error("frame tail bit is not zero");

  AST_TRAIN_ON_REQ: assert property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    req_l && ln_q.tx_cnt == FRAME_LAST
    |=> ln_q.tx_frame == sls_make_frame(TRAIN_PATTERN))
    else $error("data sent during training request");

  AST_TRAIN_LOAD: assert property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    req_l |=> ln_q.train_cnt == TRAIN_SYMBOLS)
    else $error("training count not loaded");

  AST_TRAIN_TAIL: assert property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    ln_q.train_cnt != 11'h000 && ln_q.tx_cnt == FRAME_LAST
    |=> ln_q.tx_frame == sls_make_frame(TRAIN_PATTERN) &&
        ln_q.ack_tgl == $past(ln_q.ack_tgl))
    else $error("training run cut short");

  AST_OE_UNTIL_LOCK: assert property (
    @(posedge clock) disable iff (!sys_rst_n)
    !sy_q.ever_locked && !$past(locked_s) |-> !parallel_word_oe)
    else $error("outputs driven before first lock");

  AST_STROBE_LOCKED: assert property (
    @(posedge clock) disable iff (!sys_rst_n)
    rx_word_strobe |-> parallel_word_oe && !lock_indicator)
    else $error("word presented with outputs off");

  COV_TRAIN_LOCK: cover property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    ln_q.rx_state == SLS_HUNT ##1 ln_q.rx_state == SLS_LOCKED);

  COV_LOCK_LOSS: cover property (
    @(posedge local_reference_clock) disable iff (!link_rst_n)
    ln_q.rx_state == SLS_LOCKED ##1 ln_q.rx_state == SLS_HUNT);

  COV_WORD_OUT: cover property (
    @(posedge clock) disable iff (!sys_rst_n)
    rx_word_strobe && !lock_indicator);

endmodule

// ==== testbench/sls_far_end.sv ====
// far-end serializer model: own framed words, or loop of the block's line
`timescale 1ns/1ps
module sls_far_end
  import sls_pkg::*;
(
  input  wire logic              local_reference_clock,
  input  wire logic              loop,
  input  wire logic              tx_line,
  input  wire logic [WORD_W-1:0] word,
  input  wire logic              bad,
  output logic                   rx_line,
  output logic                   frame_done
);
  logic [3:0]         cnt_q = 4'h0;
  logic [FRAME_W-1:0] sh_q  = 12'h000;

  assign frame_done = (cnt_q == 4'hb);
  assign rx_line    = loop ? tx_line : sh_q[0];

  // a bad frame flips both clock bits and data bit0, so it can be told apart
  always @(posedge local_reference_clock) begin
    cnt_q <= frame_done ? 4'h0 : cnt_q + 4'h1;
    sh_q  <= frame_done ? {bad, word ^ {9'h000, bad}, ~bad}
                        : {1'b0, sh_q[FRAME_W-1:1]};
  end
endmodule

// ==== testbench/serdes_link_lock_and_sync_test.sv ====
// self-checking bench of the serdes link lock block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module serdes_link_lock_and_sync_test
  import sls_pkg::*;
;
  logic              clock = 1'b0;
  logic              resetn = 1'b0;
  logic              local_reference_clock = 1'b0;
  logic [WORD_W-1:0] tx_word = 10'h000;
  logic              tx_valid = 1'b0;
  logic              training_request_a = 1'b0;
  logic              training_request_b = 1'b0;
  logic              tx_ready, serial_out, serial_in, frame_done;
  logic [WORD_W-1:0] parallel_word_out;
  logic              parallel_word_oe, rx_word_strobe, lock_indicator;
  logic [WORD_W-1:0] far_word = 10'h3ff;
  logic [WORD_W-1:0] mon_val = 10'h000;
  logic              loop = 1'b1, bad = 1'b0, mon = 1'b0, fb = 1'b0;
  int                err_count = 0, cmp_count = 0;

  always #5 clock = ~clock;
  // reference clock runs free, phase unrelated to the system clock
  initial begin
    #3.7;
    forever #62.5 local_reference_clock = ~local_reference_clock;
  end

  sls_top sls_top_i (.clock, .resetn, .local_reference_clock, .tx_word,
    .tx_valid, .tx_ready, .training_request_a, .training_request_b,
    .serial_out, .serial_in, .parallel_word_out, .parallel_word_oe,
    .rx_word_strobe, .lock_indicator);
  sls_far_end sls_far_end_i (.local_reference_clock, .loop,
    .tx_line(serial_out), .word(far_word), .bad, .rx_line(serial_in),
    .frame_done);

  always @(posedge clock) begin
    if (mon && rx_word_strobe === 1'b1)
      `CHK(parallel_word_out, mon_val)
    if (fb)
      training_request_a <= lock_indicator;
  end

  task automatic complete_run();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic ran_out();
    err_count++;
    $display("wait ran out at %0t", $time);
    complete_run();
  endtask

  task automatic do_reset(input logic lp);
    @(posedge clock);
    resetn <= 1'b0;
    loop <= lp;
    fb <= 1'b0;
    tx_valid <= 1'b0;
    training_request_a <= 1'b0;
    training_request_b <= 1'b0;
    // long enough for three reference clock edges
    repeat (40) @(posedge clock);
    `CHK(parallel_word_oe, 1'b0)
    `CHK(lock_indicator, 1'b1)
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  task automatic wait_lock(input logic lvl);
    int k;
    k = 0;
    while (lock_indicator !== lvl && k < 20000) begin
      @(posedge clock);
      k++;
    end
    if (lock_indicator !== lvl)
      ran_out();
  endtask

  task automatic get_word(output logic [WORD_W-1:0] w);
    int k;
    k = 0;
    w = TRAIN_PATTERN;
    while (w === TRAIN_PATTERN && k < 600) begin
      @(posedge clock);
      k++;
      if (rx_word_strobe === 1'b1)
        w = parallel_word_out;
    end
    if (w === TRAIN_PATTERN)
      ran_out();
  endtask

  task automatic lf(input int n);
    int k, lim;
    // bound fixed up front; n shrinks as frames pass
    lim = 13 * n;
    for (k = 0; k < lim && n > 0; k++) begin
      @(posedge local_reference_clock);
      if (frame_done)
        n--;
    end
    if (n > 0)
      ran_out();
  endtask

  function automatic logic [WORD_W-1:0] walk_word(input int i);
    return i[0] ? ~(10'h001 << i) : 10'h001 << i;
  endfunction

  task automatic t_fill();
    logic [WORD_W-1:0] w;
    int                i, j, k, stall;
    stall = 0;
    do_reset(1'b1);
    wait_lock(1'b0);
    `CHK(parallel_word_oe, 1'b1)
    tx_valid <= 1'b1;
    // early words return while later ones still wait, so both run at once
    fork
      begin
        // walking ones and zeros plus both end values, back to back
        for (i = 0; i < 12; i++) begin
          tx_word <= walk_word(i);
          k = 0;
          do begin
            @(posedge clock);
            k++;
          end while (tx_ready !== 1'b1 && k < 400);
          if (tx_ready !== 1'b1)
            ran_out();
          stall += k - 1;
        end
        tx_valid <= 1'b0;
      end
      for (j = 0; j < 12; j++) begin
        get_word(w);
        `CHK(w, walk_word(j))
      end
    join
    `CHK(stall != 0, 1'b1)
  endtask

  task automatic t_train(input logic use_b);
    do_reset(1'b1);
    wait_lock(1'b0);
    mon_val <= TRAIN_PATTERN;
    mon <= 1'b1;
    if (use_b)
      training_request_b <= 1'b1;
    else
      training_request_a <= 1'b1;
    repeat (300) @(posedge clock);
    tx_word <= 10'h2c3;
    tx_valid <= 1'b1;
    @(posedge clock);
    tx_valid <= 1'b0;
    repeat (4500) @(posedge clock);
    training_request_a <= 1'b0;
    training_request_b <= 1'b0;
    // the held word must stay back through about the first 40 frames of the 1024-frame trailing count
    repeat (6000) @(posedge clock);
    mon <= 1'b0;
  endtask

  task automatic t_loss();
    logic [WORD_W-1:0] w;
    bad <= 1'b0;
    far_word <= 10'h3ff;
    do_reset(1'b0);
    wait_lock(1'b0);
    `CHK(parallel_word_oe, 1'b1)
    mon_val <= 10'h3ff;
    mon <= 1'b1;
    lf(1);
    bad <= 1'b1;
    lf(3);
    bad <= 1'b0;
    lf(3);
    `CHK(lock_indicator, 1'b0)
    fb <= 1'b1;
    bad <= 1'b1;
    lf(4);
    bad <= 1'b0;
    lf(2);
    `CHK(lock_indicator, 1'b1)
    `CHK(parallel_word_oe, 1'b1)
    wait_lock(1'b0);
    `CHK(lock_indicator, 1'b0)
    // words before the loss are suspect; fresh ones must be clean again
    get_word(w);
    `CHK(w, 10'h3ff)
    lf(3);
    mon <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clock);
    t_fill();
    t_train(1'b0);
    t_train(1'b1);
    t_loss();
    complete_run();
  end
endmodule
